/* File: core/cmd_src_pkg.sv */
// Package for the command source selector: settings encodings, carriers, timing.
// Assumes a 10 MHz core clock; all users import the whole package.
package cmd_src_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int TIMEOUT_MAX_DS = 300;
	localparam int TIMEOUT_DEFAULT_DS = 100;
	localparam int DS_NS = 100_000_000;
	localparam int CLK_NS = 100;
	localparam int TICKS_PER_DS = DS_NS / CLK_NS;
	localparam logic [9:0] TIMEOUT_DEFAULT = 10'h064;
	localparam logic [9:0] TIMEOUT_MAX = 10'h12c;
	localparam int VBIT_LO = 11;
	localparam int VBIT_HI = 15;
	localparam logic [2:0] VBIT_BASE = 3'h0;
	localparam logic [2:0] VBIT_TOP = 3'h4;

	typedef enum logic [0:0] {
		PROFILE_LEGACY = 1'b0,
		PROFILE_STANDARD = 1'b1
	} profile_e;

	typedef enum logic [1:0] {
		SRC_TERMINAL = 2'b00,
		SRC_PANEL = 2'b01,
		SRC_SERIAL = 2'b10,
		SRC_FIELDBUS = 2'b11
	} source_e;

	typedef enum logic [2:0] {
		SW_FIXED_ONE = 3'b000,
		SW_FIXED_TWO = 3'b001,
		SW_INPUT_THREE = 3'b010,
		SW_INPUT_FOUR = 3'b011,
		SW_VIRTUAL = 3'b100
	} switch_sel_e;

	typedef enum logic [1:0] {
		ASG_NONE = 2'b00,
		ASG_INPUT_THREE = 2'b01,
		ASG_INPUT_FOUR = 2'b10,
		ASG_VIRTUAL = 2'b11
	} assign_e;

	typedef enum logic [1:0] {
		FN_NONE = 2'b00,
		FN_CHANNEL_SWITCH = 2'b01,
		FN_FORCED_LOCAL = 2'b10,
		FN_EXTERNAL_ERROR = 2'b11
	} input_fn_e;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_FORCED = 2'b01,
		ST_CONFIRM = 2'b10
	} force_state_e;

	typedef struct packed {
		logic run;
		logic stop;
	} cmd_s;

	typedef struct packed {
		cmd_s terminal;
		cmd_s panel;
		cmd_s serial;
		cmd_s fieldbus;
	} cmd_set_s;

	localparam cmd_s CMD_IDLE = '{run: 1'b0, stop: 1'b0};
endpackage : cmd_src_pkg

/* File: core/cmd_src_select.sv */
// Command source selector: picks the command source feeding starter sequencing.
// Assumes settings are static-ish from a config store; pins arrive asynchronously.
//
// Contract
// - Two profiles, legacy default, legacy serial-only
// - Module plug never changes selected profile
// - Module insert under legacy raises config event
// - Switch setting picks channel; default channel one
// - Switch may use command word virtual input
// - Input assignment also sets input function
// - Channel and forcing settings work only standard
// - Each channel: terminal, panel, serial, fieldbus
// - Copy channel one to two, not terminal
// - Forced local while assigned input high
// - Entering forcing stops motor without run
// - Forced source terminal or panel, needs input
// - Confirm new command within timeout after release
// - External error on input three, four, virtual
// - External error polarity selectable, default high
// - High polarity misses broken wire
`timescale 1ns/100ps
`default_nettype none
module cmd_src_select
	import cmd_src_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic PROFILE_SELECT,
	input wire logic [2:0] CHANNEL_SWITCH_SELECT,
	input wire logic [1:0] CHANNEL_ONE_SOURCE,
	input wire logic [1:0] CHANNEL_TWO_SOURCE,
	input wire logic CHANNEL_COPY_REQUEST,
	input wire logic [1:0] FORCED_LOCAL_INPUT_SELECT,
	input wire logic FORCED_LOCAL_SOURCE,
	input wire logic [9:0] FORCED_LOCAL_TIMEOUT,
	input wire logic [1:0] EXTERNAL_ERROR_INPUT_SELECT,
	input wire logic EXTERNAL_ERROR_LOW_LEVEL,
	input wire logic [2:0] SWITCH_VIRTUAL_BIT,
	input wire logic [2:0] ERROR_VIRTUAL_BIT,
	input wire logic [15:0] FIELDBUS_COMMAND_WORD,
	input wire logic DIGITAL_INPUT_THREE,
	input wire logic DIGITAL_INPUT_FOUR,
	input wire logic FIELDBUS_MODULE_PRESENT,
	input wire cmd_set_s SOURCE_CMDS,
	output cmd_s ACTIVE_CMD,
	output logic ACTIVE_SELECTS_TWO,
	output logic [1:0] ACTIVE_SOURCE,
	output logic [1:0] CHANNEL_TWO_EFFECTIVE,
	output logic COPY_REFUSED,
	output logic FORCED_LOCAL_ACTIVE,
	output logic FORCED_STOP,
	output logic CONFIRM_PENDING,
	output logic CONFIRM_TIMEOUT_EVENT,
	output logic CONFIG_CHANGE_EVENT,
	output logic EXTERNAL_ERROR_EVENT,
	output logic [1:0] INPUT_THREE_FUNCTION,
	output logic [1:0] INPUT_FOUR_FUNCTION
);
	logic rst_meta_ff, rst_n_ff;
	logic [1:0] di3_sync_ff, di4_sync_ff, plug_sync_ff;
	logic plug_prev_ff;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// Pins are unsynchronised; only the second stage is read
	always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			di3_sync_ff <= '0;
			di4_sync_ff <= '0;
			plug_sync_ff <= '0;
		end else if (CE) begin
			di3_sync_ff <= {di3_sync_ff[0], DIGITAL_INPUT_THREE};
			di4_sync_ff <= {di4_sync_ff[0], DIGITAL_INPUT_FOUR};
			plug_sync_ff <= {plug_sync_ff[0], FIELDBUS_MODULE_PRESENT};
		end
	end

	logic di3, di4, plugged;
	assign di3 = di3_sync_ff[1];
	assign di4 = di4_sync_ff[1];
	assign plugged = plug_sync_ff[1];

	function automatic logic vbit(input logic [15:0] word, input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > VBIT_TOP) ? VBIT_TOP : sel;
		return word[VBIT_LO + int'(s)];
	endfunction : vbit

	function automatic cmd_s pick(input cmd_set_s set, input logic [1:0] src);
		case (source_e'(src))
			SRC_TERMINAL: return set.terminal;
			SRC_PANEL: return set.panel;
			SRC_SERIAL: return set.serial;
			SRC_FIELDBUS: return set.fieldbus;
			default: return CMD_IDLE;
		endcase
	endfunction : pick

	logic is_std;
	assign is_std = (PROFILE_SELECT == PROFILE_STANDARD);

	// Legacy profile ignores channel settings; serial bus only
	logic [2:0] sw_sel;
	logic [1:0] flo_sel;
	assign sw_sel = is_std ? CHANNEL_SWITCH_SELECT : SW_FIXED_ONE;
	assign flo_sel = is_std ? FORCED_LOCAL_INPUT_SELECT : ASG_NONE;

	// Copy register: channel two keeps the source channel one had when copied
	logic copied_ff, nxt_copied;
	logic [1:0] ch2_copy_ff, nxt_ch2_copy;
	logic refused_ff, nxt_refused;
	logic copy_prev_ff;

	always_comb begin
		nxt_copied = copied_ff;
		nxt_ch2_copy = ch2_copy_ff;
		nxt_refused = refused_ff;
		if (CHANNEL_COPY_REQUEST && !copy_prev_ff && is_std) begin
			if (CHANNEL_ONE_SOURCE == SRC_TERMINAL) begin
				nxt_refused = 1'b1;
			end else begin
				nxt_refused = 1'b0;
				nxt_copied = 1'b1;
				nxt_ch2_copy = CHANNEL_ONE_SOURCE;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			copied_ff <= 1'b0;
			ch2_copy_ff <= SRC_TERMINAL;
			refused_ff <= 1'b0;
			copy_prev_ff <= 1'b0;
		end else if (CE) begin
			copied_ff <= nxt_copied;
			ch2_copy_ff <= nxt_ch2_copy;
			refused_ff <= nxt_refused;
			copy_prev_ff <= CHANNEL_COPY_REQUEST;
		end
	end

	logic [1:0] ch2_src;
	assign ch2_src = copied_ff ? ch2_copy_ff : CHANNEL_TWO_SOURCE;

	// Channel choice
	logic sel_two;
	always_comb begin
		case (switch_sel_e'(sw_sel))
			SW_FIXED_ONE: sel_two = 1'b0;
			SW_FIXED_TWO: sel_two = 1'b1;
			SW_INPUT_THREE: sel_two = di3;
			SW_INPUT_FOUR: sel_two = di4;
			SW_VIRTUAL: sel_two = vbit(FIELDBUS_COMMAND_WORD, SWITCH_VIRTUAL_BIT);
			default: sel_two = 1'b0;
		endcase
	end

	logic [1:0] chan_src;
	assign chan_src = !is_std ? SRC_SERIAL : (sel_two ? ch2_src : CHANNEL_ONE_SOURCE);

	// Forced local request
	logic force_req;
	always_comb begin
		case (assign_e'(flo_sel))
			ASG_INPUT_THREE: force_req = di3;
			ASG_INPUT_FOUR: force_req = di4;
			default: force_req = 1'b0;
		endcase
	end

	// Panel choice only meaningful with an input assigned
	logic [1:0] force_src;
	assign force_src = FORCED_LOCAL_SOURCE ? SRC_PANEL : SRC_TERMINAL;

	// Forcing sequence
	force_state_e st_ff, nxt_st;
	logic fstop_ff, nxt_fstop;
	logic tmo_start, tmo_exp;
	cmd_s chan_cmd, force_cmd;
	assign chan_cmd = pick(SOURCE_CMDS, chan_src);
	assign force_cmd = pick(SOURCE_CMDS, force_src);

	always_comb begin
		nxt_st = st_ff;
		nxt_fstop = fstop_ff;
		tmo_start = 1'b0;
		case (st_ff)
			ST_NORMAL: begin
				if (force_req) begin
					nxt_st = ST_FORCED;
					nxt_fstop = !force_cmd.run;
				end
			end
			ST_FORCED: begin
				if (force_cmd.run) begin
					nxt_fstop = 1'b0;
				end
				if (!force_req) begin
					nxt_st = ST_CONFIRM;
					nxt_fstop = 1'b0;
					tmo_start = 1'b1;
				end
			end
			ST_CONFIRM: begin
				if (force_req) begin
					nxt_st = ST_FORCED;
					nxt_fstop = !force_cmd.run;
				end else if (chan_cmd.run || chan_cmd.stop || tmo_exp) begin
					nxt_st = ST_NORMAL;
				end
			end
			default: nxt_st = ST_NORMAL;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff <= ST_NORMAL;
			fstop_ff <= 1'b0;
		end else if (CE) begin
			st_ff <= nxt_st;
			fstop_ff <= nxt_fstop;
		end
	end

	cmd_src_timeout cmd_src_timeout_inst (
		.clk(CORE_CLK),
		.rst_n(rst_n_ff),
		.ce(CE),
		.start(tmo_start),
		.cancel(st_ff != ST_CONFIRM),
		.limit_ds((FORCED_LOCAL_TIMEOUT > TIMEOUT_MAX) ? TIMEOUT_MAX : FORCED_LOCAL_TIMEOUT),
		.expired(tmo_exp)
	);

	// External error
	logic err_raw, err_lvl;
	always_comb begin
		case (assign_e'(EXTERNAL_ERROR_INPUT_SELECT))
			ASG_INPUT_THREE: err_raw = di3;
			ASG_INPUT_FOUR: err_raw = di4;
			ASG_VIRTUAL: err_raw = vbit(FIELDBUS_COMMAND_WORD, ERROR_VIRTUAL_BIT);
			default: err_raw = 1'b0;
		endcase
	end
	// Low polarity turns an open wire into a detected error
	assign err_lvl = (EXTERNAL_ERROR_INPUT_SELECT != ASG_NONE)
		&& (EXTERNAL_ERROR_LOW_LEVEL ? !err_raw : err_raw);

	// Input function mirrors; forcing wins, then switching, then error
	function automatic logic [1:0] input_fn(input logic [1:0] pin_code, input logic [2:0] sw_pin);
		if (flo_sel == pin_code) return FN_FORCED_LOCAL;
		if (sw_sel == sw_pin) return FN_CHANNEL_SWITCH;
		if (EXTERNAL_ERROR_INPUT_SELECT == pin_code) return FN_EXTERNAL_ERROR;
		return FN_NONE;
	endfunction : input_fn

	// Output registers
	cmd_s out_cmd_ff, nxt_out_cmd;
	logic [1:0] out_src_ff, fn3_ff, fn4_ff;
	logic sel_two_ff, cfg_ev_ff, err_ev_ff, tmo_ev_ff;

	always_comb begin
		if (st_ff == ST_FORCED) begin
			nxt_out_cmd = force_cmd;
			if (fstop_ff) begin
				nxt_out_cmd = '{run: 1'b0, stop: 1'b1};
			end
		end else begin
			nxt_out_cmd = chan_cmd;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			out_cmd_ff <= CMD_IDLE;
			out_src_ff <= SRC_SERIAL;
			sel_two_ff <= 1'b0;
			fn3_ff <= FN_NONE;
			fn4_ff <= FN_NONE;
			plug_prev_ff <= 1'b0;
			cfg_ev_ff <= 1'b0;
			err_ev_ff <= 1'b0;
			tmo_ev_ff <= 1'b0;
		end else if (CE) begin
			out_cmd_ff <= nxt_out_cmd;
			out_src_ff <= (st_ff == ST_FORCED) ? force_src : chan_src;
			sel_two_ff <= sel_two;
			fn3_ff <= input_fn(ASG_INPUT_THREE, SW_INPUT_THREE);
			fn4_ff <= input_fn(ASG_INPUT_FOUR, SW_INPUT_FOUR);
			plug_prev_ff <= plugged;
			cfg_ev_ff <= plugged && !plug_prev_ff && !is_std;
			err_ev_ff <= err_lvl;
			tmo_ev_ff <= tmo_exp;
		end
	end

	assign ACTIVE_CMD = out_cmd_ff;
	assign ACTIVE_SOURCE = out_src_ff;
	assign ACTIVE_SELECTS_TWO = sel_two_ff;
	assign CHANNEL_TWO_EFFECTIVE = ch2_copy_ff;
	assign COPY_REFUSED = refused_ff;
	assign FORCED_LOCAL_ACTIVE = (st_ff == ST_FORCED);
	assign FORCED_STOP = fstop_ff;
	assign CONFIRM_PENDING = (st_ff == ST_CONFIRM);
	assign CONFIRM_TIMEOUT_EVENT = tmo_ev_ff;
	assign CONFIG_CHANGE_EVENT = cfg_ev_ff;
	assign EXTERNAL_ERROR_EVENT = err_ev_ff;
	assign INPUT_THREE_FUNCTION = fn3_ff;
	assign INPUT_FOUR_FUNCTION = fn4_ff;
endmodule : cmd_src_select
`default_nettype wire

/* File: core/cmd_src_timeout.sv */
// Confirmation timer after forced-local release, counts tenths of a second.
// Assumes start is a one-cycle pulse and ce freezes all state.
`timescale 1ns/100ps
`default_nettype none
module cmd_src_timeout
	import cmd_src_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic cancel,
	input wire logic [9:0] limit_ds,
	output logic expired
);
	logic [23:0] tick_ff, nxt_tick;
	logic [9:0] ds_ff, nxt_ds;
	logic run_ff, nxt_run;
	logic exp_ff, nxt_exp;

	always_comb begin
		nxt_tick = tick_ff;
		nxt_ds = ds_ff;
		nxt_run = run_ff;
		nxt_exp = 1'b0;
		if (start) begin
			nxt_run = 1'b1;
			nxt_tick = '0;
			nxt_ds = '0;
		end else if (cancel) begin
			nxt_run = 1'b0;
		end else if (run_ff) begin
			if (tick_ff == 24'(TICKS_PER_DS - 1)) begin
				nxt_tick = '0;
				nxt_ds = ds_ff + 10'h001;
				if (ds_ff + 10'h001 >= limit_ds) begin
					nxt_run = 1'b0;
					nxt_exp = 1'b1;
				end
			end else begin
				nxt_tick = tick_ff + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_ff <= '0;
			ds_ff <= '0;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else if (ce) begin
			tick_ff <= nxt_tick;
			ds_ff <= nxt_ds;
			run_ff <= nxt_run;
			exp_ff <= nxt_exp;
		end
	end

	assign expired = exp_ff;
endmodule : cmd_src_timeout
`default_nettype wire

/* File: verif/cmd_src_checker.sv */
// Checker on the selector's top ports: source choice, forcing and events.
// Assumes settings stay steady while a checked relation runs.
`timescale 1ns/100ps
`default_nettype none
module cmd_src_checker
	import cmd_src_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic PROFILE_SELECT,
	input wire logic [2:0] CHANNEL_SWITCH_SELECT,
	input wire logic [1:0] FORCED_LOCAL_INPUT_SELECT,
	input wire logic [1:0] EXTERNAL_ERROR_INPUT_SELECT,
	input wire cmd_set_s SOURCE_CMDS,
	input wire cmd_s ACTIVE_CMD,
	input wire logic ACTIVE_SELECTS_TWO,
	input wire logic [1:0] ACTIVE_SOURCE,
	input wire logic FORCED_LOCAL_ACTIVE,
	input wire logic FORCED_STOP,
	input wire logic CONFIRM_PENDING,
	input wire logic CONFIG_CHANGE_EVENT,
	input wire logic EXTERNAL_ERROR_EVENT
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);
	logic normal;
	assign normal = PROFILE_SELECT && !FORCED_LOCAL_ACTIVE && !CONFIRM_PENDING;
	property p_legacy; !PROFILE_SELECT [*4] |-> ACTIVE_SOURCE == SRC_SERIAL && !FORCED_LOCAL_ACTIVE; endproperty
	a_legacy: assert property (p_legacy) else $error("legacy left serial");
	property p_cfg_pulse; CONFIG_CHANGE_EVENT |=> !CONFIG_CHANGE_EVENT; endproperty
	a_cfg_pulse: assert property (p_cfg_pulse) else $error("config event too long");
	property p_cfg_legacy; CONFIG_CHANGE_EVENT |-> !PROFILE_SELECT && !$past(PROFILE_SELECT); endproperty
	a_cfg_legacy: assert property (p_cfg_legacy) else $error("config event in standard");
	// Switch inputs are kept out: they go through a synchroniser
	property p_fixed;
		($past(NRST, 3) && normal && $stable(CHANNEL_SWITCH_SELECT) && CHANNEL_SWITCH_SELECT < 3'h2) [*3]
		|-> ACTIVE_SELECTS_TWO == CHANNEL_SWITCH_SELECT[0];
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed channel ignored");
	property p_follow;
		$past(NRST, 3) && normal && $past(normal) && $stable(ACTIVE_SOURCE)
		|-> ACTIVE_CMD == 2'($past(SOURCE_CMDS) >> (6 - 2 * ACTIVE_SOURCE));
	endproperty
	a_follow: assert property (p_follow) else $error("command not from active source");
	property p_fstop; $rose(FORCED_STOP) |=> ACTIVE_CMD.stop && !ACTIVE_CMD.run; endproperty
	a_fstop: assert property (p_fstop) else $error("forced stop not issued");
	property p_force_ok; FORCED_LOCAL_ACTIVE |-> PROFILE_SELECT && FORCED_LOCAL_INPUT_SELECT inside {2'h1, 2'h2}; endproperty
	a_force_ok: assert property (p_force_ok) else $error("forcing without input");
	property p_err_none; (EXTERNAL_ERROR_INPUT_SELECT == ASG_NONE) [*4] |-> !EXTERNAL_ERROR_EVENT; endproperty
	a_err_none: assert property (p_err_none) else $error("error unassigned but raised");
	c_cfg: cover property (CONFIG_CHANGE_EVENT);
	c_fstop: cover property ($rose(FORCED_STOP));
	c_confirm: cover property ($fell(CONFIRM_PENDING));
endmodule : cmd_src_checker
bind cmd_src_select cmd_src_checker cmd_src_checker_inst (.CORE_CLK, .NRST, .PROFILE_SELECT,
	.CHANNEL_SWITCH_SELECT, .FORCED_LOCAL_INPUT_SELECT, .EXTERNAL_ERROR_INPUT_SELECT, .SOURCE_CMDS,
	.ACTIVE_CMD, .ACTIVE_SELECTS_TWO, .ACTIVE_SOURCE, .FORCED_LOCAL_ACTIVE, .FORCED_STOP,
	.CONFIRM_PENDING, .CONFIG_CHANGE_EVENT, .EXTERNAL_ERROR_EVENT);
`default_nettype wire

/* File: verif/cmd_src_partner.sv */
// Far side: the four command sources and the input pins.
// Assumes requests are set between edges; all answers move on the edge.
`timescale 1ns/100ps
`default_nettype none
module cmd_src_partner
	import cmd_src_pkg::*;
(
	input wire logic clk,
	input wire cmd_set_s want,
	input wire logic [2:0] pins,
	input wire logic ack,
	input wire logic pend,
	output var cmd_set_s cmds_ff,
	output var logic [2:0] pins_ff
);
	cmd_set_s nxt_cmds;
	always_comb begin
		nxt_cmds = want;
		// Operator confirms only when told to, so a slow reply stays possible
		if (ack && pend)
			nxt_cmds.panel.stop = 1'b1;
	end
	always_ff @(posedge clk) begin
		cmds_ff <= nxt_cmds;
		pins_ff <= pins;
	end
endmodule : cmd_src_partner
`default_nettype wire

/* File: verif/cmd_src_select_bench.sv */
// Bench for the selector: one task per scenario, partner drives sources.
// Assumes 10 MHz clock; settings change only between checks.
`timescale 1ns/100ps
`default_nettype none
module cmd_src_select_bench
	import cmd_src_pkg::*;
;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, prof = 1'b0, cpy = 1'b0, forced_local_source = 1'b0, low = 1'b0, ack = 1'b0;
	logic [2:0] sw = 3'h0, swb = 3'h0, erb = 3'h2, pins = 3'h0, pq;
	logic [1:0] c1 = 2'h0, c2 = 2'h0, forced_local_input_select = 2'h2, external_error_input_select = 2'h0, asrc, eff, f3, f4;
	logic [9:0] forced_local_timeout = 10'h001;
	logic [15:0] word = 16'h0;
	cmd_set_s want = '0, src;
	cmd_s cmd;
	logic two, refused, forced, fstop, pend, tmo, cfg, err;
	int bad_count = 0;
	int check_count = 0;
	always #50 clk = ~clk;
	cmd_src_partner cmd_src_partner_inst (.clk(clk), .want(want), .pins(pins), .ack(ack), .pend(pend),
		.cmds_ff(src), .pins_ff(pq));
	cmd_src_select cmd_src_select_inst (.CORE_CLK(clk), .NRST(nrst), .CE(ce), .PROFILE_SELECT(prof),
		.CHANNEL_SWITCH_SELECT(sw), .CHANNEL_ONE_SOURCE(c1), .CHANNEL_TWO_SOURCE(c2),
		.CHANNEL_COPY_REQUEST(cpy), .FORCED_LOCAL_INPUT_SELECT(forced_local_input_select), .FORCED_LOCAL_SOURCE(forced_local_source),
		.FORCED_LOCAL_TIMEOUT(forced_local_timeout), .EXTERNAL_ERROR_INPUT_SELECT(external_error_input_select), .EXTERNAL_ERROR_LOW_LEVEL(low),
		.SWITCH_VIRTUAL_BIT(swb), .ERROR_VIRTUAL_BIT(erb), .FIELDBUS_COMMAND_WORD(word),
		.DIGITAL_INPUT_THREE(pq[0]), .DIGITAL_INPUT_FOUR(pq[1]), .FIELDBUS_MODULE_PRESENT(pq[2]),
		.SOURCE_CMDS(src), .ACTIVE_CMD(cmd), .ACTIVE_SELECTS_TWO(two), .ACTIVE_SOURCE(asrc),
		.CHANNEL_TWO_EFFECTIVE(eff), .COPY_REFUSED(refused), .FORCED_LOCAL_ACTIVE(forced),
		.FORCED_STOP(fstop), .CONFIRM_PENDING(pend), .CONFIRM_TIMEOUT_EVENT(tmo),
		.CONFIG_CHANGE_EVENT(cfg), .EXTERNAL_ERROR_EVENT(err), .INPUT_THREE_FUNCTION(f3),
		.INPUT_FOUR_FUNCTION(f4));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize;
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic t_legacy;
		logic seen;
		want = 8'h08;
		pins = 3'h2;
		cyc(6);
		chk(asrc, SRC_SERIAL);
		chk(cmd, 2'h2);
		chk(2'(forced), 2'h0);
		pins = 3'h6;
		seen = 1'b0;
		for (int n = 0; n < 8; n++) begin
			cyc(1);
			seen = seen | cfg;
		end
		chk(2'(seen), 2'h1);
		chk(asrc, SRC_SERIAL);
		// Drop DI4 before going standard, else forcing starts
		pins = 3'h0;
		cyc(6);
		prof = 1'b1;
		pins = 3'h4;
		seen = 1'b0;
		for (int n = 0; n < 8; n++) begin
			cyc(1);
			seen = seen | cfg;
		end
		chk(2'(seen), 2'h0);
	endtask : t_legacy
	task automatic t_switch;
		forced_local_input_select = 2'h0;
		want = 8'h9c;
		for (int k = 0; k < 4; k++) begin
			c1 = 2'(k);
			c2 = 2'(3 - k);
			sw = SW_FIXED_ONE;
			cyc(4);
			chk(asrc, 2'(k));
			chk(cmd, 2'(want >> (6 - 2 * k)));
			sw = SW_FIXED_TWO;
			cyc(4);
			chk(cmd, 2'(want >> (2 * k)));
		end
		for (int d = 0; d < 4; d++) begin
			sw = d[1] ? SW_INPUT_FOUR : SW_INPUT_THREE;
			pins = {1'b1, d[1] & d[0], !d[1] & d[0]};
			cyc(6);
			chk(2'(two), 2'(d[0]));
			chk(d[1] ? f4 : f3, FN_CHANNEL_SWITCH);
		end
		sw = SW_VIRTUAL;
		for (int b = 0; b < 5; b++) begin
			swb = 3'(b);
			word = 16'h0800 << b;
			cyc(4);
			chk(2'(two), 2'h1);
			word = ~word;
			cyc(4);
			chk(2'(two), 2'h0);
		end
		word = 16'h0;
		sw = SW_FIXED_ONE;
		pins = 3'h4;
	endtask : t_switch
	task automatic t_forced;
		want = 8'h8c;
		forced_local_input_select = 2'h2;
		// Channel one on the panel, where the operator confirms
		c1 = SRC_PANEL;
		for (int s = 0; s < 2; s++) begin
			forced_local_source = s[0];
			pins = 3'h6;
			cyc(6);
			chk(2'(forced), 2'h1);
			chk(2'(fstop), 2'(s));
			chk(cmd, s[0] ? 2'h1 : 2'h2);
			chk(asrc, 2'(s));
			chk(f4, FN_FORCED_LOCAL);
			pins = 3'h4;
			cyc(6);
			chk(2'(pend), 2'h1);
			chk(2'(tmo), 2'h0);
			ack = 1'b1;
			cyc(6);
			chk(2'(pend), 2'h0);
			ack = 1'b0;
		end
		forced_local_input_select = 2'h0;
		pins = 3'h6;
		cyc(6);
		chk(2'(forced), 2'h0);
	endtask : t_forced
	task automatic t_error;
		for (int e = 1; e < 4; e++) begin
			for (int m = 0; m < 4; m++) begin
				external_error_input_select = 2'(e);
				low = m[1];
				pins = {1'b1, e == 2 && m[0], e == 1 && m[0]};
				word = m[0] ? 16'h2000 : 16'h0;
				cyc(6);
				chk(2'(err), 2'(m[0] ^ m[1]));
				if (e < 3)
					chk(e == 1 ? f3 : f4, FN_EXTERNAL_ERROR);
			end
		end
		external_error_input_select = 2'h0;
		pins = 3'h5;
		cyc(6);
		chk(2'(err), 2'h0);
	endtask : t_error
	task automatic t_copy;
		c1 = SRC_TERMINAL;
		cpy = 1'b1;
		cyc(4);
		chk(2'(refused), 2'h1);
		cpy = 1'b0;
		c1 = SRC_SERIAL;
		cyc(2);
		cpy = 1'b1;
		cyc(4);
		chk(2'(refused), 2'h0);
		chk(eff, SRC_SERIAL);
		sw = SW_FIXED_TWO;
		cyc(4);
		chk(asrc, SRC_SERIAL);
	endtask : t_copy
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		summarize();
	end
	initial begin
		cyc(16);
		nrst = 1'b1;
		cyc(8);
		t_legacy();
		t_switch();
		t_forced();
		t_error();
		t_copy();
		summarize();
	end
endmodule : cmd_src_select_bench
`default_nettype wire
